// ---- hw/burst_order.sv ----
// column order generator for one read or write burst
module burst_order
  import dram_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic rst_b,
  // request and beats
  burst_if.gen bus
);
  logic [3:0] idx_reg;
  logic run_reg;
  logic wr_reg;
  logic il_reg;
  logic chop_reg;
  logic [2:0] s_reg;
  logic [2:0] i;
  logic [2:0] col_next;
  logic last_half;

  assign i = idx_reg[2:0];
  assign last_half = i[2];

  // beat column from start and index
  always_comb
  begin
    if (wr_reg)
      col_next = chop_reg ? {s_reg[2], i[1:0]} : i;
    else if (il_reg)
      col_next = s_reg ^ i;
    else
      col_next = {s_reg[2] ^ i[2], 2'(s_reg[1:0] + i[1:0])};
  end

  // request capture and beat counter
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idx_reg <= 4'h0;
      run_reg <= 1'b0;
      wr_reg <= 1'b0;
      il_reg <= 1'b0;
      chop_reg <= 1'b0;
      s_reg <= COL_RST;
    end
    else if (bus.start && !run_reg)
    begin
      idx_reg <= 4'h0;
      run_reg <= 1'b1;
      wr_reg <= bus.is_write;
      il_reg <= bus.interleaved;
      chop_reg <= bus.chop;
      s_reg <= bus.start_col;
    end
    else if (run_reg)
    begin
      idx_reg <= idx_reg + 4'h1;
      run_reg <= (idx_reg != BEATS_BL8 - 4'h1);
    end
  end

  // registered beat outputs
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus.beat <= 1'b0;
      bus.col <= COL_RST;
      bus.dq_oe_b <= 1'b1;
      bus.busy <= 1'b0;
    end
    else
    begin
      bus.busy <= run_reg || bus.start;
      bus.beat <= run_reg && !(chop_reg && last_half);
      bus.col <= run_reg ? col_next : COL_RST;
      bus.dq_oe_b <= !(run_reg && !wr_reg && !(chop_reg && last_half));
    end
  end
endmodule

// ---- hw/dram_cke_ctrl.sv ----
// clock-enable power states, command handling and burst launch of the memory device
//
// Overview of operation
// - act per edge on state, cke history, command
// - self-refresh entry only from idle with refresh
// - power-down type follows banks open or closed
// - no refresh while powered down
// - low cke holds state, pins ignored
// - no termination in self-refresh, otherwise no effect
// - idle means closed, quiet, cke high, timed
// - mode bit selects sequential or interleaved
// - mode bits select burst length option
// - read beat columns from start and index
// - chop read: four beats then tristate
// - write order fixed, chop picks half
// - fixed chop write starts two clocks early
// - per-command chop write keeps normal start
// - bursts always complete, never interrupted
// - crc fixed length write needs column zero
module dram_cke_ctrl
  import dram_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic rst_b,
  // link pins
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic [ADDR_W-1:0] addr,
  // mode configuration
  input wire logic [1:0] bl_mode,
  input wire logic burst_interleave,
  input wire logic wr_crc_en,
  input wire logic sr_exit_nop_ok,
  // status
  output logic [8:0] power_state,
  output logic pd_is_active,
  output logic refresh_busy,
  output logic odt_on,
  output logic idle,
  output logic cmd_seq_err,
  output logic crc_col_err,
  output logic wr_internal_start,
  // burst beats
  output logic beat_valid,
  output logic [2:0] beat_col,
  output logic dq_oe_b
);
  localparam int SW = ADDR_W + 8;

  // ------------------------------------------------------------
  // pin synchroniser and clock edge finder
  // ------------------------------------------------------------
  logic [SW-1:0] pin_meta_reg;
  logic [SW-1:0] pin_reg;
  logic ck_last_reg;
  logic edge_hit;
  logic ck_s;
  logic cke_s;
  logic odt_s;
  logic [ADDR_W-1:0] addr_s;
  logic [4:0] ctl_s;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta_reg <= '0;
      pin_reg <= '0;
      ck_last_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= {ck, cke, cs_n, act_n, ras_n, cas_n, we_n, odt, addr};
      pin_reg <= pin_meta_reg;
      ck_last_reg <= ck_s;
    end
  end

  assign {ck_s, cke_s, ctl_s, odt_s, addr_s} = pin_reg;
  assign edge_hit = ck_s && !ck_last_reg;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  cmd_e cmd;

  always_comb
  begin
    if (ctl_s[4])
      cmd = CMD_DES;
    else if (!ctl_s[3])
      cmd = CMD_ACT;
    else
      unique case (ctl_s[2:0])
        3'b111: cmd = CMD_NOP;
        3'b001: cmd = CMD_REF;
        3'b010: cmd = CMD_PRE;
        3'b101: cmd = CMD_RD;
        3'b100: cmd = CMD_WR;
        default: cmd = CMD_OTHER;
      endcase
  end

  // ------------------------------------------------------------
  // burst request set-up
  // ------------------------------------------------------------
  burst_if bus ();
  logic chop_sel;
  logic rdwr;
  logic crc_bad;
  logic [7:0] wr_target;

  assign chop_sel = (bl_mode == BL_FIXED4) || (bl_mode == BL_OTF && !addr_s[A_BL_SEL]);
  assign rdwr = (cmd == CMD_RD) || (cmd == CMD_WR);
  assign crc_bad = wr_crc_en && bl_mode == BL_FIXED8 && cmd == CMD_WR && addr_s[2:0] != 3'h0;
  assign wr_target = (bl_mode == BL_FIXED4) ? WR_START_EDGES - WR_CHOP_PULL_IN
                                            : WR_START_EDGES;

  burst_order u_order (
    .clock(clock),
    .rst_b(rst_b),
    .bus(bus)
  );

  // ------------------------------------------------------------
  // power and activity state machine
  // ------------------------------------------------------------
  pstate_e state_reg;
  logic cke_prev_reg;
  logic banks_open_reg;
  logic auto_pre_reg;
  logic pd_act_reg;
  logic [7:0] wait_reg;
  logic [7:0] wr_cnt_reg;
  logic start_reg;
  logic is_wr_reg;
  logic il_reg;
  logic chop_reg;
  logic [2:0] scol_reg;
  logic err_reg;
  logic crc_err_reg;
  logic wr_start_reg;

  assign bus.start = start_reg;
  assign bus.is_write = is_wr_reg;
  assign bus.interleaved = il_reg;
  assign bus.chop = chop_reg;
  assign bus.start_col = scol_reg;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      cke_prev_reg <= 1'b1;
      banks_open_reg <= 1'b0;
      auto_pre_reg <= 1'b0;
      pd_act_reg <= 1'b0;
      wait_reg <= WAIT_RST;
      wr_cnt_reg <= WAIT_RST;
      start_reg <= 1'b0;
      is_wr_reg <= 1'b0;
      il_reg <= 1'b0;
      chop_reg <= 1'b0;
      scol_reg <= COL_RST;
      err_reg <= 1'b0;
      crc_err_reg <= 1'b0;
      wr_start_reg <= 1'b0;
    end
    else
    begin
      start_reg <= 1'b0;
      err_reg <= 1'b0;
      crc_err_reg <= 1'b0;
      wr_start_reg <= 1'b0;
      if (edge_hit)
      begin
        cke_prev_reg <= cke_s;
        if (wait_reg != WAIT_RST)
          wait_reg <= wait_reg - 8'h01;
        unique case (state_reg)
          ST_PWR_DOWN:
          begin
            if (cke_s)
            begin
              if (cmd == CMD_DES)
              begin
                state_reg <= ST_EXITING;
                wait_reg <= T_XP_EDGES;
              end
              else
                err_reg <= 1'b1;
            end
          end
          ST_SELF_REF:
          begin
            if (cke_s)
            begin
              if (cmd == CMD_DES || (cmd == CMD_NOP && sr_exit_nop_ok))
              begin
                state_reg <= ST_EXITING;
                wait_reg <= T_XS_EDGES;
              end
              else
                err_reg <= 1'b1;
            end
          end
          default:
          begin
            if (!cke_s)
            begin
              if (cmd == CMD_DES)
              begin
                state_reg <= ST_PWR_DOWN;
                pd_act_reg <= banks_open_reg && !auto_pre_reg;
                if (auto_pre_reg)
                  banks_open_reg <= 1'b0;
                auto_pre_reg <= 1'b0;
                wait_reg <= WAIT_RST;
              end
              else if (cmd == CMD_REF && state_reg == ST_IDLE)
                state_reg <= ST_SELF_REF;
              else
                err_reg <= 1'b1;
            end
            else if (state_reg == ST_IDLE || state_reg == ST_ACTIVE)
            begin
              if (cmd == CMD_ACT)
              begin
                banks_open_reg <= 1'b1;
                state_reg <= ST_ACTIVE;
              end
              else if (cmd == CMD_REF && state_reg == ST_IDLE)
              begin
                state_reg <= ST_REFRESHING;
                wait_reg <= T_RFC_EDGES;
              end
              else if (cmd == CMD_PRE)
              begin
                banks_open_reg <= 1'b0;
                state_reg <= ST_PRECHARGING;
                wait_reg <= T_RP_EDGES;
              end
              else if (crc_bad)
                crc_err_reg <= 1'b1;
              else if (rdwr && banks_open_reg)
              begin
                start_reg <= 1'b1;
                is_wr_reg <= (cmd == CMD_WR);
                il_reg <= burst_interleave;
                chop_reg <= chop_sel;
                scol_reg <= addr_s[2:0];
                auto_pre_reg <= addr_s[A_AUTO_PRE];
                wr_cnt_reg <= WAIT_RST;
                state_reg <= (cmd == CMD_WR) ? ST_WRITING : ST_READING;
              end
              else if (cmd != CMD_DES && cmd != CMD_NOP)
                err_reg <= 1'b1;
            end
            else
            begin
              if (cmd != CMD_DES && cmd != CMD_NOP)
                err_reg <= 1'b1;
              if (state_reg == ST_WRITING)
              begin
                wr_cnt_reg <= wr_cnt_reg + 8'h01;
                if (wr_cnt_reg + 8'h01 == wr_target)
                  wr_start_reg <= 1'b1;
              end
              if ((state_reg == ST_READING && !bus.busy) ||
                  (state_reg == ST_WRITING && wr_cnt_reg + 8'h01 >= wr_target && !bus.busy))
              begin
                if (auto_pre_reg)
                begin
                  banks_open_reg <= 1'b0;
                  auto_pre_reg <= 1'b0;
                  state_reg <= ST_PRECHARGING;
                  wait_reg <= T_RP_EDGES;
                end
                else
                  state_reg <= ST_ACTIVE;
              end
              else if ((state_reg == ST_PRECHARGING || state_reg == ST_REFRESHING ||
                        state_reg == ST_EXITING) && wait_reg <= 8'h01)
                state_reg <= banks_open_reg ? ST_ACTIVE : ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // registered status
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      power_state <= ST_IDLE;
      pd_is_active <= 1'b0;
      refresh_busy <= 1'b0;
      odt_on <= 1'b0;
      idle <= 1'b0;
      cmd_seq_err <= 1'b0;
      crc_col_err <= 1'b0;
      wr_internal_start <= 1'b0;
    end
    else
    begin
      power_state <= state_reg;
      pd_is_active <= (state_reg == ST_PWR_DOWN) && pd_act_reg;
      refresh_busy <= (state_reg == ST_REFRESHING) || (state_reg == ST_SELF_REF);
      odt_on <= odt_s && (state_reg != ST_SELF_REF);
      idle <= (state_reg == ST_IDLE) && cke_prev_reg && !bus.busy;
      cmd_seq_err <= err_reg;
      crc_col_err <= crc_err_reg;
      wr_internal_start <= wr_start_reg;
    end
  end

  // ------------------------------------------------------------
  // burst beat outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      beat_valid <= 1'b0;
      beat_col <= COL_RST;
      dq_oe_b <= 1'b1;
    end
    else
    begin
      beat_valid <= bus.beat;
      beat_col <= bus.col;
      dq_oe_b <= bus.dq_oe_b;
    end
  end
endmodule

// ---- shared/burst_if.sv ----
// carries a burst request to the column order generator and its beats back
interface burst_if;
  logic start;
  logic is_write;
  logic interleaved;
  logic chop;
  logic [2:0] start_col;
  logic beat;
  logic [2:0] col;
  logic dq_oe_b;
  logic busy;
  modport ctrl (output start, is_write, interleaved, chop, start_col,
                input beat, col, dq_oe_b, busy);
  modport gen (input start, is_write, interleaved, chop, start_col,
               output beat, col, dq_oe_b, busy);
endinterface

// ---- shared/dram_pkg.sv ----
// constants, state and command codes for the clock-enable state and burst order block
package dram_pkg;
  // one-hot power and activity states
  typedef enum logic [8:0] {
    ST_IDLE        = 9'h001,
    ST_ACTIVE      = 9'h002,
    ST_READING     = 9'h004,
    ST_WRITING     = 9'h008,
    ST_PRECHARGING = 9'h010,
    ST_REFRESHING  = 9'h020,
    ST_PWR_DOWN    = 9'h040,
    ST_SELF_REF    = 9'h080,
    ST_EXITING     = 9'h100
  } pstate_e;

  typedef enum logic [2:0] {
    CMD_DES   = 3'h0,
    CMD_NOP   = 3'h1,
    CMD_ACT   = 3'h2,
    CMD_REF   = 3'h3,
    CMD_PRE   = 3'h4,
    CMD_RD    = 3'h5,
    CMD_WR    = 3'h6,
    CMD_OTHER = 3'h7
  } cmd_e;

  localparam int ADDR_W = 14;
  // burst length field codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  // address bit positions
  localparam int A_AUTO_PRE = 10;
  localparam int A_BL_SEL = 12;
  // burst beats
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  // link clock counts
  localparam logic [7:0] WR_START_EDGES = 8'h04;
  localparam logic [7:0] WR_CHOP_PULL_IN = 8'h02;
  localparam logic [7:0] T_RP_EDGES = 8'h04;
  localparam logic [7:0] T_RFC_EDGES = 8'h10;
  localparam logic [7:0] T_XP_EDGES = 8'h03;
  localparam logic [7:0] T_XS_EDGES = 8'h10;
  // reset values
  localparam logic [7:0] WAIT_RST = 8'h00;
  localparam logic [2:0] COL_RST = 3'h0;
endpackage

// ---- tb/dram_cke_assertions.sv ----
// concurrent checks on the clock-enable state and burst order block
module dram_cke_assertions
  import dram_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic rst_b,
  // pins and status
  input wire logic cke,
  input wire logic [8:0] power_state,
  input wire logic pd_is_active,
  input wire logic refresh_busy,
  input wire logic odt_on,
  input wire logic idle,
  input wire logic cmd_seq_err,
  input wire logic crc_col_err,
  input wire logic beat_valid,
  input wire logic dq_oe_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] low_reg;
  // clocks with cke low, saturating
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      low_reg <= 4'h0;
    else if (cke)
      low_reg <= 4'h0;
    else if (low_reg != 4'hF)
      low_reg <= low_reg + 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // --------
  // properties
  // --------
  property p_hold;
    low_reg == 4'hF && $past(power_state) inside {ST_PWR_DOWN, ST_SELF_REF}
      |-> power_state == $past(power_state);
  endproperty
  a_hold: assert property (p_hold) else $error("state left with cke low");
  property p_pd_ref;
    power_state == ST_PWR_DOWN |-> !refresh_busy;
  endproperty
  a_pd_ref: assert property (p_pd_ref) else $error("refresh in power-down");
  property p_sr_odt;
    power_state == ST_SELF_REF |-> !odt_on && refresh_busy;
  endproperty
  a_sr_odt: assert property (p_sr_odt) else $error("termination in self-refresh");
  property p_pd_kind;
    pd_is_active |-> power_state == ST_PWR_DOWN;
  endproperty
  a_pd_kind: assert property (p_pd_kind) else $error("active flag outside power-down");
  property p_idle;
    idle |-> power_state == ST_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag in busy state");
  property p_beats;
    $rose(beat_valid) |-> beat_valid [*4];
  endproperty
  a_beats: assert property (p_beats) else $error("burst cut short");
  property p_oe;
    !dq_oe_b |-> beat_valid;
  endproperty
  a_oe: assert property (p_oe) else $error("driver on without beat");
  property p_err;
    cmd_seq_err |=> !cmd_seq_err;
  endproperty
  a_err: assert property (p_err) else $error("error pulse too long");
  property p_crc;
    crc_col_err |=> !crc_col_err;
  endproperty
  a_crc: assert property (p_crc) else $error("crc pulse too long");
  property p_onehot;
    $onehot(power_state);
  endproperty
  a_onehot: assert property (p_onehot) else $error("state not one-hot");
endmodule

bind dram_cke_ctrl dram_cke_assertions chk (.clock(clock), .rst_b(rst_b), .cke(cke),
  .power_state(power_state), .pd_is_active(pd_is_active), .refresh_busy(refresh_busy),
  .odt_on(odt_on), .idle(idle), .cmd_seq_err(cmd_seq_err), .crc_col_err(crc_col_err),
  .beat_valid(beat_valid), .dq_oe_b(dq_oe_b));

// ---- tb/mem_ctrl_model.sv ----
// memory controller model driving link clock, clock enable, command and address
module mem_ctrl_model
  import dram_pkg::*;
(
  // link pins
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic act_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic odt,
  output logic [ADDR_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------
  // link clock and pins
  // --------
  initial
  begin
    ck = 1'b0;
    cke = 1'b1;
    {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
    odt = 1'b0;
    addr = '0;
    #3;
    forever #40 ck = ~ck;
  end
  // termination request, changed away from the sampling edge
  task automatic term(input logic v);
    @(negedge ck);
    odt = v;
  endtask
  task automatic issue(input cmd_e c, input logic k, input logic [ADDR_W-1:0] a);
    logic [4:0] p;
    @(negedge ck);
    case (c)
      CMD_NOP: p = 5'h0F;
      CMD_ACT: p = 5'h07;
      CMD_REF: p = 5'h09;
      CMD_PRE: p = 5'h0A;
      CMD_RD: p = 5'h0D;
      CMD_WR: p = 5'h0C;
      default: p = {1'b1, ~act_n, ~ras_n, ~cas_n, ~we_n};
    endcase
    {cs_n, act_n, ras_n, cas_n, we_n} = p;
    cke = k;
    // ignored address keeps toggling so a stale value never looks valid
    addr = (c == CMD_DES) ? ~addr : a;
    @(posedge ck);
  endtask
endmodule

// ---- tb/tb_dram_cke_state_and_burst_order.sv ----
// self-checking bench for the clock-enable state and burst order block
module tb_dram_cke_state_and_burst_order
  import dram_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_b, ck, cke, cs_n, act_n, ras_n, cas_n, we_n, odt;
  logic [ADDR_W-1:0] addr;
  logic [1:0] bl_mode;
  logic burst_interleave, wr_crc_en, sr_exit_nop_ok;
  logic [8:0] power_state;
  logic pd_is_active, refresh_busy, odt_on, idle, cmd_seq_err, crc_col_err;
  logic wr_internal_start, beat_valid, dq_oe_b;
  logic [2:0] beat_col;
  logic [2:0] q[$];
  logic seq_seen, crc_seen;
  int err_total, n_tests, oe_n;
  longint t0, t_ws, d_8, d_otf, d_fix;

  mem_ctrl_model ctl (.ck(ck), .cke(cke), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .odt(odt), .addr(addr));
  dram_cke_ctrl uut (.clock(clock), .rst_b(rst_b), .ck(ck), .cke(cke), .cs_n(cs_n),
    .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .addr(addr),
    .bl_mode(bl_mode), .burst_interleave(burst_interleave), .wr_crc_en(wr_crc_en),
    .sr_exit_nop_ok(sr_exit_nop_ok), .power_state(power_state), .pd_is_active(pd_is_active),
    .refresh_busy(refresh_busy), .odt_on(odt_on), .idle(idle), .cmd_seq_err(cmd_seq_err),
    .crc_col_err(crc_col_err), .wr_internal_start(wr_internal_start),
    .beat_valid(beat_valid), .beat_col(beat_col), .dq_oe_b(dq_oe_b));

  always #5 clock = ~clock;
  // collects beats and pulses
  always @(posedge clock)
  begin
    if (beat_valid === 1'b1)
      q.push_back(beat_col);
    if (dq_oe_b === 1'b0)
      oe_n++;
    if (cmd_seq_err === 1'b1)
      seq_seen = 1'b1;
    if (crc_col_err === 1'b1)
      crc_seen = 1'b1;
    if (wr_internal_start === 1'b1)
      t_ws = $time;
  end
  // --------
  // tasks
  // --------
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic mode(input logic [1:0] b, input logic il, input logic c, input logic n);
    @(posedge clock);
    #1;
    bl_mode = b;
    burst_interleave = il;
    wr_crc_en = c;
    sr_exit_nop_ok = n;
  endtask
  task automatic des(input int n, input logic k);
    repeat (n) ctl.issue(CMD_DES, k, '0);
  endtask
  task automatic burst(input logic w, input logic [2:0] s, input logic a12, input int n);
    logic [2:0] e;
    q.delete();
    oe_n = 0;
    crc_seen = 1'b0;
    ctl.issue(w ? CMD_WR : CMD_RD, 1'b1, {1'b0, a12, 9'h0, s});
    t0 = $time;
    des(5, 1'b1);
    check(9'(q.size()), 9'(n));
    check(9'(oe_n), w ? 9'h0 : 9'(n));
    foreach (q[i])
    begin
      e = 3'(i);
      if (w && n == 4)
        e = {s[2], e[1:0]};
      if (!w)
        e = burst_interleave ? s ^ e : {s[2] ^ e[2], s[1:0] + e[1:0]};
      check(9'(q[i]), 9'(e));
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // --------
  // sequence
  // --------
  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end
  initial
  begin
    clock = 1'b0;
    rst_b = 1'b0;
    {seq_seen, crc_seen} = 2'h0;
    t_ws = 0;
    bl_mode = BL_FIXED8;
    {burst_interleave, wr_crc_en, sr_exit_nop_ok} = 3'h0;
    repeat (12) @(posedge clock);
    #1;
    rst_b = 1'b1;
    check(power_state, ST_IDLE);
    ctl.issue(CMD_ACT, 1'b1, '0);
    des(1, 1'b1);
    check(power_state, ST_ACTIVE);
    for (int il = 0; il < 2; il++)
      for (int s = 0; s < 8; s++)
      begin
        mode(BL_FIXED8, il[0], 1'b0, 1'b0);
        burst(1'b0, 3'(s), 1'b1, 8);
      end
    mode(BL_OTF, 1'b1, 1'b0, 1'b0);
    burst(1'b0, 3'h3, 1'b0, 4);
    burst(1'b0, 3'h5, 1'b1, 8);
    mode(BL_FIXED4, 1'b0, 1'b0, 1'b0);
    burst(1'b0, 3'h6, 1'b1, 4);
    mode(BL_FIXED8, 1'b0, 1'b0, 1'b0);
    burst(1'b1, 3'h5, 1'b1, 8);
    d_8 = t_ws - t0;
    mode(BL_OTF, 1'b0, 1'b0, 1'b0);
    burst(1'b1, 3'h6, 1'b0, 4);
    d_otf = t_ws - t0;
    mode(BL_FIXED4, 1'b0, 1'b0, 1'b0);
    burst(1'b1, 3'h2, 1'b1, 4);
    d_fix = t_ws - t0;
    check(9'((d_otf - d_8 + 40) / 80), 9'h0);
    check(9'((d_otf - d_fix + 40) / 80), 9'h2);
    mode(BL_FIXED8, 1'b0, 1'b1, 1'b0);
    burst(1'b1, 3'h3, 1'b1, 0);
    check(9'(crc_seen), 9'h1);
    burst(1'b1, 3'h0, 1'b1, 8);
    check(9'(crc_seen), 9'h0);
    mode(BL_FIXED8, 1'b0, 1'b0, 1'b0);
    q.delete();
    seq_seen = 1'b0;
    ctl.issue(CMD_RD, 1'b1, 14'h0001);
    ctl.issue(CMD_RD, 1'b1, 14'h0004);
    des(4, 1'b1);
    check(9'(q.size()), 9'h8);
    check(9'(seq_seen), 9'h1);
    ctl.issue(CMD_DES, 1'b0, '0);
    ctl.issue(CMD_REF, 1'b0, 14'h1FFF);
    ctl.issue(CMD_RD, 1'b0, '0);
    check(power_state, ST_PWR_DOWN);
    check(9'({pd_is_active, refresh_busy}), 9'h2);
    des(5, 1'b1);
    check(power_state, ST_ACTIVE);
    ctl.issue(CMD_PRE, 1'b1, '0);
    des(5, 1'b1);
    check(power_state, ST_IDLE);
    des(2, 1'b0);
    check(9'({power_state == ST_PWR_DOWN, pd_is_active}), 9'h2);
    des(5, 1'b1);
    check(9'(idle), 9'h1);
    for (int k = 0; k < 2; k++)
    begin
      mode(BL_FIXED8, 1'b0, 1'b0, k[0]);
      ctl.term(1'b1);
      ctl.issue(CMD_REF, 1'b0, '0);
      check(9'(odt_on), 9'h1);
      des(2, 1'b0);
      check(power_state, ST_SELF_REF);
      check(9'({refresh_busy, odt_on}), 9'h2);
      ctl.term(1'b0);
      seq_seen = 1'b0;
      if (k == 0)
        ctl.issue(CMD_NOP, 1'b1, '0);
      ctl.issue(k ? CMD_NOP : CMD_DES, 1'b1, '0);
      des(1, 1'b1);
      check(9'(seq_seen), 9'(k == 0));
      check(power_state, ST_EXITING);
      des(18, 1'b1);
      check(9'(idle), 9'h1);
    end
    ctl.issue(CMD_ACT, 1'b1, '0);
    ctl.issue(CMD_RD, 1'b1, 14'h0400);
    des(2, 1'b0);
    check(9'({power_state == ST_PWR_DOWN, pd_is_active}), 9'h2);
    des(5, 1'b1);
    ctl.issue(CMD_ACT, 1'b1, '0);
    des(2, 1'b0);
    check(9'({power_state == ST_PWR_DOWN, pd_is_active}), 9'h3);
    des(5, 1'b1);
    ctl.issue(CMD_ACT, 1'b1, '0);
    ctl.issue(CMD_REF, 1'b0, '0);
    des(2, 1'b0);
    check(9'(power_state == ST_SELF_REF), 9'h0);
    stop_test();
  end
endmodule
